// File: pkg/timer_pulse_pkg.sv
// Shared constants for the pulse-width and variable-period timer block.
package timer_pulse_pkg;

	// Counter and bus widths.
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses on the APB.
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CMP_ZERO = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CMP_ONE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

	// Field positions in the control register.
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam int CTRL_VPP_BIT = 2;
	localparam int CTRL_EN0_BIT = 3;
	localparam int CTRL_ALV0_BIT = 4;
	localparam int CTRL_EN1_BIT = 5;
	localparam int CTRL_ALV1_BIT = 6;
	localparam int CTRL_SEL_LSB = 8;
	localparam int SEL_W = 4;

	// Field positions in the status register.
	localparam int STAT_M0_BIT = 0;
	localparam int STAT_M1_BIT = 1;

	// Prescaler: divide by eight shifted left by the select code, codes 0 to 8.
	localparam int DIV_W = 12;
	localparam logic [DIV_W-1:0] DIV_BASE = 12'h008;
	localparam logic [SEL_W-1:0] SEL_MAX = 4'h8;

	// Reset values.
	localparam logic [CNT_W-1:0] CMP_RST = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [SEL_W-1:0] SEL_RST = 4'h0;

endpackage : timer_pulse_pkg

// File: design/count_prescaler.sv
`timescale 1ns/10ps
// Divides pclk into one-cycle count ticks by 8, 16, ... 2048.
module count_prescaler
	import timer_pulse_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [timer_pulse_pkg::SEL_W-1:0] sel,
	output logic tick
);
	import timer_pulse_pkg::*;

	// Whole state of the divider.
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} presc_state_t;

	presc_state_t st_ff;
	presc_state_t nxt_st;
	logic [DIV_W-1:0] div_last;

	// Codes above the largest divider are clamped to it.
	assign div_last = (sel > SEL_MAX) ? (DIV_BASE << SEL_MAX) - 12'h001 : (DIV_BASE << sel) - 12'h001;

	// The divider restarts while stopped, so the first tick comes a full division after start.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (!run)
		begin
			nxt_st.cnt = '0;
		end
		else if (st_ff.cnt >= div_last)
		begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
		end
		else
		begin
			nxt_st.cnt = st_ff.cnt + 12'h001;
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign tick = st_ff.tick;

endmodule : count_prescaler

// File: design/pulse_channel.sv
`timescale 1ns/10ps
// Drives one timer output pin from period start and compare match events.
module pulse_channel
	import timer_pulse_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic enable,
	input wire logic alv,
	input wire logic allowed,
	input wire logic start,
	input wire logic match,
	output logic pin
);
	import timer_pulse_pkg::*;

	// Whole state of the channel: pin level and the once-per-period guard.
	typedef struct packed {
		logic pin;
		logic done;
	} chan_state_t;

	chan_state_t st_ff;
	chan_state_t nxt_st;

	// Active level is the inverse of the select bit; inactive equals it.
	always_comb
	begin
		nxt_st = st_ff;
		if (!enable || !allowed)
		begin
			nxt_st.pin = ~alv;
			nxt_st.done = 1'b0;
		end
		else if (!run)
		begin
			nxt_st.pin = ~alv;
			nxt_st.done = 1'b0;
		end
		else if (start)
		begin
			nxt_st.pin = ~alv;
			nxt_st.done = 1'b0;
		end
		else if (match && !st_ff.done)
		begin
			// Only the first match in a period changes the pin.
			nxt_st.pin = alv;
			nxt_st.done = 1'b1;
		end
	end

	// State register; the pin resets to the active level of a zero select bit.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= '{pin: 1'b1, done: 1'b0};
		else
			st_ff <= nxt_st;
	end

	assign pin = st_ff.pin;

endmodule : pulse_channel

// File: design/timer_pwm_ppg_output.sv
`timescale 1ns/10ps
// Functional notes
// - Fixed-period mode period is 65536 ticks.
// - Each compare register sets its output width.
// - Count clock is pclk divided 8 to 2048.
// - One output change per period only.
// - Compare below count gives full duty.
// - Stopping in fixed-period mode drives active.
// - Disabled pin shows inverse of level select.
// - Variable period is compare-one plus one.
// - Variable-period wave only on output zero.
// - Repeat compare-zero matches are ignored.
// - Late compare-zero rewrite gives full duty.
// - Short compare-one lets counter wrap fully.
// - After match, inactive until the wrap.
// - Before match, active until match, again wrap.
// - Match raises its request with output change.
// - Stopping variable-period output drives active.
// - Disabled pin high when select zero.
module timer_pwm_ppg_output
	import timer_pulse_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [timer_pulse_pkg::ADDR_W-1:0] paddr,
	input wire logic [timer_pulse_pkg::DATA_W-1:0] pwdata,
	output logic [timer_pulse_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pulse_out_zero,
	output logic pulse_out_one,
	output logic match_zero_irq,
	output logic match_one_irq
);
	import timer_pulse_pkg::*;

	// Whole register and counter state of the block.
	typedef struct packed {
		logic counter_run;
		logic clear_on_compare_one;
		logic variable_period_pulse;
		logic output_enable_zero;
		logic active_level_select_zero;
		logic output_enable_one;
		logic active_level_select_one;
		logic [SEL_W-1:0] presc_sel;
		logic [CNT_W-1:0] compare_zero;
		logic [CNT_W-1:0] compare_one;
		logic [CNT_W-1:0] timer_count;
		logic flag_zero;
		logic flag_one;
		logic irq_zero;
		logic irq_one;
		logic [DATA_W-1:0] rdata;
		logic slverr;
		logic ready;
	} timer_state_t;

	timer_state_t st_ff;
	timer_state_t nxt_st;

	// Count tick from the prescaler.
	logic tick;
	// Counter value after this cycle.
	logic [CNT_W-1:0] count_step;
	// Events on the edge at which the counter takes count_step.
	logic advance;
	logic period_start;
	logic hit_zero;
	logic hit_one;
	// Bus phases.
	logic setup_phase;
	logic write_access;

	// Returns the counter value after one tick.
	function automatic logic [CNT_W-1:0] next_count(
		input logic [CNT_W-1:0] cur,
		input logic clr,
		input logic [CNT_W-1:0] top
	);
		// Clearing on compare one is an equality test, so a top below the count wraps at all ones.
		if (clr && (cur == top))
			next_count = CNT_RST;
		else
			next_count = cur + CNT_ONE;
	endfunction : next_count

	assign advance = st_ff.counter_run && tick;
	assign count_step = advance ? next_count(st_ff.timer_count, st_ff.clear_on_compare_one, st_ff.compare_one)
		: (st_ff.counter_run ? st_ff.timer_count : CNT_RST);
	assign period_start = advance && (count_step == CNT_RST);
	assign hit_zero = advance && (count_step == st_ff.compare_zero);
	assign hit_one = advance && (count_step == st_ff.compare_one);
	assign setup_phase = psel && !penable;
	assign write_access = psel && penable && pwrite;

	// Register file, counter and match flags.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.timer_count = count_step;
		nxt_st.irq_zero = hit_zero;
		nxt_st.irq_one = hit_one;
		nxt_st.ready = 1'b1;
		// Writes take effect in the access phase.
		if (write_access)
		begin
			unique case (paddr)
				OFF_CTRL:
				begin
					nxt_st.counter_run = pwdata[CTRL_RUN_BIT];
					nxt_st.clear_on_compare_one = pwdata[CTRL_CLR_BIT];
					nxt_st.variable_period_pulse = pwdata[CTRL_VPP_BIT];
					nxt_st.output_enable_zero = pwdata[CTRL_EN0_BIT];
					nxt_st.active_level_select_zero = pwdata[CTRL_ALV0_BIT];
					nxt_st.output_enable_one = pwdata[CTRL_EN1_BIT];
					nxt_st.active_level_select_one = pwdata[CTRL_ALV1_BIT];
					nxt_st.presc_sel = pwdata[CTRL_SEL_LSB +: SEL_W];
				end
				OFF_CMP_ZERO:
				begin
					nxt_st.compare_zero = pwdata[CNT_W-1:0];
				end
				OFF_CMP_ONE:
				begin
					nxt_st.compare_one = pwdata[CNT_W-1:0];
				end
				OFF_STATUS:
				begin
					// Write one to clear.
					if (pwdata[STAT_M0_BIT])
						nxt_st.flag_zero = 1'b0;
					if (pwdata[STAT_M1_BIT])
						nxt_st.flag_one = 1'b0;
				end
				default:
				begin
					// The count register and unmapped addresses ignore writes.
				end
			endcase
		end
		// A match in the clearing cycle still sets its flag.
		if (hit_zero)
			nxt_st.flag_zero = 1'b1;
		if (hit_one)
			nxt_st.flag_one = 1'b1;
		// Read data and error are prepared in the setup phase.
		if (setup_phase)
		begin
			nxt_st.rdata = '0;
			nxt_st.slverr = 1'b0;
			unique case (paddr)
				OFF_CTRL:
				begin
					nxt_st.rdata[CTRL_RUN_BIT] = st_ff.counter_run;
					nxt_st.rdata[CTRL_CLR_BIT] = st_ff.clear_on_compare_one;
					nxt_st.rdata[CTRL_VPP_BIT] = st_ff.variable_period_pulse;
					nxt_st.rdata[CTRL_EN0_BIT] = st_ff.output_enable_zero;
					nxt_st.rdata[CTRL_ALV0_BIT] = st_ff.active_level_select_zero;
					nxt_st.rdata[CTRL_EN1_BIT] = st_ff.output_enable_one;
					nxt_st.rdata[CTRL_ALV1_BIT] = st_ff.active_level_select_one;
					nxt_st.rdata[CTRL_SEL_LSB +: SEL_W] = st_ff.presc_sel;
				end
				OFF_CMP_ZERO:
					nxt_st.rdata[CNT_W-1:0] = st_ff.compare_zero;
				OFF_CMP_ONE:
					nxt_st.rdata[CNT_W-1:0] = st_ff.compare_one;
				OFF_COUNT:
					nxt_st.rdata[CNT_W-1:0] = st_ff.timer_count;
				OFF_STATUS:
				begin
					nxt_st.rdata[STAT_M0_BIT] = st_ff.flag_zero;
					nxt_st.rdata[STAT_M1_BIT] = st_ff.flag_one;
				end
				default:
					nxt_st.slverr = 1'b1;
			endcase
		end
	end

	// State register with every control bit cleared and compares at full scale.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= '0;
			st_ff.compare_zero <= CMP_RST;
			st_ff.compare_one <= CMP_RST;
			st_ff.presc_sel <= SEL_RST;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// Count clock divider.
	count_prescaler u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.run(st_ff.counter_run),
		.sel(st_ff.presc_sel),
		.tick(tick)
	);

	// Output zero serves both pulse modes.
	pulse_channel u_chan_zero (
		.pclk(pclk),
		.presetn(presetn),
		.run(st_ff.counter_run),
		.enable(st_ff.output_enable_zero),
		.alv(st_ff.active_level_select_zero),
		.allowed(1'b1),
		.start(period_start),
		.match(hit_zero),
		.pin(pulse_out_zero)
	);

	// Output one stays at its fixed level in variable-period mode.
	pulse_channel u_chan_one (
		.pclk(pclk),
		.presetn(presetn),
		.run(st_ff.counter_run),
		.enable(st_ff.output_enable_one),
		.alv(st_ff.active_level_select_one),
		.allowed(!st_ff.variable_period_pulse),
		.start(period_start),
		.match(hit_one),
		.pin(pulse_out_one)
	);

	assign prdata = st_ff.rdata;
	assign pready = st_ff.ready;
	assign pslverr = st_ff.slverr;
	assign match_zero_irq = st_ff.irq_zero;
	assign match_one_irq = st_ff.irq_one;

	// Checks on the timing of the counter and pins.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// The counter steps by one on a tick; a compare one below the count is passed and the count wraps.
	AST_COUNT_STEP: assert property (
		advance && !(st_ff.clear_on_compare_one && st_ff.timer_count == st_ff.compare_one)
		|=> st_ff.timer_count == $past(st_ff.timer_count) + CNT_ONE)
		else $error("Counter did not step by one.");
	// With clear on compare one set, the counter returns to zero on the tick after compare one.
	AST_CLEAR_ON_ONE: assert property (
		advance && st_ff.clear_on_compare_one && st_ff.timer_count == st_ff.compare_one
		|=> st_ff.timer_count == CNT_RST)
		else $error("Counter did not clear after compare one.");
	// Ticks come every eighth cycle at the smallest divider.
	AST_TICK_DIV8: assert property (
		(tick && st_ff.presc_sel == SEL_RST && st_ff.counter_run)
		##1 (st_ff.counter_run && st_ff.presc_sel == SEL_RST)[*7] |=> tick)
		else $error("Tick spacing wrong for divide by eight.");
	// A stopped counter drives the active level on an enabled output.
	AST_STOP_ACTIVE: assert property (
		!st_ff.counter_run && st_ff.output_enable_zero
		|=> pulse_out_zero == !$past(st_ff.active_level_select_zero))
		else $error("Stopped output not at active level.");
	// A disabled output shows the inverse of its select bit.
	AST_DISABLED_LEVEL: assert property (
		!st_ff.output_enable_zero
		|=> pulse_out_zero == !$past(st_ff.active_level_select_zero))
		else $error("Disabled output not at inverse select level.");
	// Output one keeps its fixed level in variable-period mode.
	AST_ONE_NOT_VPP: assert property (
		st_ff.variable_period_pulse
		|=> pulse_out_one == !$past(st_ff.active_level_select_one))
		else $error("Output one moved in variable-period mode.");
	// Without a match the active level stays, so a compare below the count gives full duty.
	AST_HOLD_ACTIVE: assert property (
		st_ff.counter_run && st_ff.output_enable_zero && !hit_zero
		&& pulse_out_zero == !st_ff.active_level_select_zero
		|=> pulse_out_zero == !$past(st_ff.active_level_select_zero))
		else $error("Output left active level without a match.");
	// Once inactive, an output waits for the period start; later matches change nothing.
	AST_INACTIVE_HOLD: assert property (
		st_ff.counter_run && st_ff.output_enable_zero && !period_start
		&& pulse_out_zero == st_ff.active_level_select_zero
		|=> pulse_out_zero == $past(st_ff.active_level_select_zero))
		else $error("Inactive output changed before the period start.");
	// Each match raises its request for one cycle together with its flag.
	AST_MATCH_IRQ: assert property (
		hit_zero |=> match_zero_irq && st_ff.flag_zero ##1 !match_zero_irq)
		else $error("Match request not raised for one cycle.");
	AST_MATCH_ONE_IRQ: assert property (
		hit_one |=> match_one_irq && st_ff.flag_one ##1 !match_one_irq)
		else $error("Match one request not raised for one cycle.");
	// The period start drives the active level again.
	AST_START_ACTIVE: assert property (
		period_start && st_ff.output_enable_zero
		|=> pulse_out_zero == !$past(st_ff.active_level_select_zero))
		else $error("Period start did not drive active level.");

	// Main scenarios: a match in variable-period mode, a wrap, a stop and a clear on compare one.
	COV_VPP_MATCH: cover property (st_ff.variable_period_pulse && hit_zero);
	COV_PWM_WRAP: cover property (!st_ff.clear_on_compare_one && period_start);
	COV_STOP: cover property (st_ff.counter_run ##1 !st_ff.counter_run);
	COV_VPP_CLEAR: cover property (advance && st_ff.clear_on_compare_one
		&& st_ff.timer_count == st_ff.compare_one ##1 st_ff.timer_count == CNT_RST);

endmodule : timer_pwm_ppg_output

// File: bench/pulse_load.sv
`timescale 1ns/10ps
// External load on one timer pin: measures active-high width and period in pclk cycles.
module pulse_load
	import timer_pulse_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	output int hi_len,
	output int per_len
);
	logic prv_ff; // Pin level seen at the previous edge.
	int cnt_ff; // Cycles since the last rising edge.

	// A rising edge closes one period, a falling edge closes the high time.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prv_ff <= 1'b1;
			cnt_ff <= 0;
			hi_len <= 0;
			per_len <= 0;
		end
		else
		begin
			prv_ff <= pin;
			cnt_ff <= (pin && !prv_ff) ? 1 : cnt_ff + 1;
			if (pin && !prv_ff)
				per_len <= cnt_ff;
			if (!pin && prv_ff)
				hi_len <= cnt_ff;
		end
	end
endmodule : pulse_load

// File: bench/timer_pwm_ppg_output_bench.sv
`timescale 1ns/10ps
// Drives software accesses over APB and judges the two pulse pins.
module timer_pwm_ppg_output_bench;
	import timer_pulse_pkg::*;
	localparam int run_m = 1 << CTRL_RUN_BIT, clr_m = 1 << CTRL_CLR_BIT, vpp_m = 1 << CTRL_VPP_BIT,
		en0_m = 1 << CTRL_EN0_BIT, al0_m = 1 << CTRL_ALV0_BIT, en1_m = 1 << CTRL_EN1_BIT, al1_m = 1 << CTRL_ALV1_BIT;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic [DATA_W-1:0] prdata;
	logic [DATA_W-1:0] rd;
	logic pready, pslverr, err;
	logic pulse_out_zero, pulse_out_one, match_zero_irq, match_one_irq;
	logic [31:0] seed = 32'h000156e3;
	int fails = 0;
	int cmp_count = 0;
	int n, c0, c1, hi, per;

	// A 100 ns clock.
	always #50 pclk = ~pclk;

	timer_pwm_ppg_output dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pulse_out_zero(pulse_out_zero), .pulse_out_one(pulse_out_one),
		.match_zero_irq(match_zero_irq), .match_one_irq(match_one_irq));
	pulse_load load0 (.pclk(pclk), .presetn(presetn), .pin(pulse_out_zero), .hi_len(hi), .per_len(per));

	// Draws a value in lo..up from the xorshift stream.
	function automatic int pick(input int lo, input int up);
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return lo + int'(seed % (up - lo + 1));
	endfunction : pick

	// Edges from a run write until a change made after the given ticks is seen.
	function automatic int match_edges(input int ticks, input int sel);
		return ticks * (8 << sel) + 1;
	endfunction : match_edges

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	// Counts edges until the signal shows the level; a hang ends the run.
	task automatic edges_until(ref logic s, input logic v, output int k);
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (s !== v && k < 40000);
		if (s !== v)
		begin
			fails++;
			give_verdict();
		end
	endtask : edges_until

	// Counts the cycles in which the signal leaves the level.
	task automatic count_off(ref logic s, input logic v, input int k, output int m);
		m = 0;
		repeat (k)
		begin
			@(posedge pclk);
			m += (s !== v);
		end
	endtask : count_off

	// One APB transfer; read data and error are taken at the completing edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		edges_until(pready, 1'b1, k);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		chk({pulse_out_zero, pulse_out_one}, 32'h3);
		@(posedge pclk);
		apb(1'b0, 8'h14, 32'h0);
		chk(err, 1'b1);
		for (int a = 0; a < 2; a++)
		begin
			apb(1'b1, OFF_CTRL, a * (al0_m | al1_m));
			repeat (2) @(posedge pclk);
			chk({pulse_out_zero, pulse_out_one}, a ? 32'h0 : 32'h3);
		end
		apb(1'b1, OFF_CMP_ZERO, 32'h2);
		for (int s = 0; s <= 9; s++)
		begin
			apb(1'b1, OFF_CTRL, run_m | en0_m | (s << CTRL_SEL_LSB));
			edges_until(match_zero_irq, 1'b1, n);
			chk(n, match_edges(2, (s > 8) ? 8 : s));
			apb(1'b1, OFF_CTRL, 32'h0);
		end
		// Fixed period: width, ignored rematch, late rewrite, stop.
		c0 = pick(1, 15);
		apb(1'b1, OFF_CMP_ZERO, c0);
		apb(1'b1, OFF_CMP_ONE, c0 + 20);
		apb(1'b1, OFF_CTRL, run_m | en0_m | en1_m);
		edges_until(pulse_out_zero, 1'b0, n);
		chk(n, match_edges(c0, 0));
		apb(1'b1, OFF_CMP_ZERO, c0 + 4);
		edges_until(match_zero_irq, 1'b1, n);
		chk(pulse_out_zero, 1'b0);
		apb(1'b1, OFF_CMP_ONE, 32'h1);
		repeat (240) @(posedge pclk);
		chk(pulse_out_one, 1'b1);
		apb(1'b1, OFF_CTRL, en0_m | en1_m);
		repeat (2) @(posedge pclk);
		chk({pulse_out_zero, pulse_out_one}, 32'h3);
		// Variable period with random compares kept within the legal range.
		c1 = pick(5, 12);
		c0 = pick(4, c1);
		apb(1'b1, OFF_CMP_ZERO, c0);
		apb(1'b1, OFF_CMP_ONE, c1);
		apb(1'b1, OFF_CTRL, run_m | clr_m | vpp_m | en0_m | en1_m);
		count_off(pulse_out_one, 1'b1, 24 * (c1 + 1) + 9, n);
		chk(n, 0);
		chk(per, 8 * (c1 + 1));
		chk(hi, 8 * c0);
		edges_until(match_one_irq, 1'b1, n);
		repeat (24) @(posedge pclk);
		apb(1'b1, OFF_CMP_ZERO, 32'h1);
		count_off(pulse_out_zero, 1'b1, 8 * c1 - 8, n);
		chk(n, 0);
		edges_until(pulse_out_zero, 1'b0, n);
		apb(1'b1, OFF_CTRL, clr_m | vpp_m | en0_m | en1_m);
		repeat (2) @(posedge pclk);
		chk(pulse_out_zero, 1'b1);
		apb(1'b0, OFF_COUNT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, OFF_STATUS, 32'h3);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h0);
		give_verdict();
	end
endmodule : timer_pwm_ppg_output_bench
